// ===== hw/gvps_map.vh
// Timing, step and encoding constants for the gas valve proving sequencer
`ifndef GVPS_MAP_VH
`define GVPS_MAP_VH
// Unsigned 32-bit so the full cycle count does not overflow a signed integer
`define GVPS_CLK_HZ          32'h02faf080
`define GVPS_MS_DIV          32'h000003e8
`define GVPS_STEP_MS         32'h000009c4
`define GVPS_STEP_CYCLES     ((`GVPS_CLK_HZ / `GVPS_MS_DIV) * `GVPS_STEP_MS)
`define GVPS_VALVE_MS        32'h00000fa0
`define GVPS_VALVE_CYCLES    ((`GVPS_CLK_HZ / `GVPS_MS_DIV) * `GVPS_VALVE_MS)
`define GVPS_CYCLE_MS        32'h00011940
`define GVPS_CYCLE_CYCLES    ((`GVPS_CLK_HZ / `GVPS_MS_DIV) * `GVPS_CYCLE_MS)
`define GVPS_EVAC_STEPS      5'h0a
`define GVPS_PRES_STEPS      5'h0c
`define GVPS_MODE_PRESTART   2'h0
`define GVPS_MODE_POSTSTOP   2'h1
`define GVPS_MODE_BOTH       2'h2
`define GVPS_PH_IDLE         3'h0
`define GVPS_PH_EVAC         3'h1
`define GVPS_PH_PRES         3'h2
`define GVPS_PH_RETURN       3'h3
`define GVPS_PH_DONE         3'h4
`endif

// ===== hw/gvps_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module gvps_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input  wire             clk,
	input  wire             nrst,
	// Raw and filtered levels
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] s1;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (!nrst) begin
					s1[i]   <= 1'b0;
					s2[i]   <= 1'b0;
					s3[i]   <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					s1[i] <= din[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						dout[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule // gvps_sync
`default_nettype wire

// ===== hw/gvps_top.v
// Gas valve proving sequencer top level
`timescale 1ns/100ps
`default_nettype none
`include "gvps_map.vh"
module gvps_top #(
	parameter STEP_CYCLES  = `GVPS_STEP_CYCLES,
	parameter VALVE_CYCLES = `GVPS_VALVE_CYCLES,
	parameter CYCLE_CYCLES = `GVPS_CYCLE_CYCLES
) (
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Configuration
	input  wire [1:0] start_mode,
	// Burner demand and switch
	input  wire       burner_demand,
	input  wire       press_high,
	// Reset buttons
	input  wire       reset_front,
	input  wire       reset_remote,
	// Valve drives
	output reg        valve_down,
	output reg        valve_up,
	// Permission and indication
	output reg        relay_main,
	output reg        relay_aux,
	output reg        lockout,
	output reg        reset_lamp,
	output reg  [2:0] ind_phase,
	output reg  [4:0] ind_step
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_EVAC  = 3'h1;
	localparam ST_PRES  = 3'h2;
	localparam ST_RET   = 3'h3;
	localparam ST_RUN   = 3'h4;
	localparam ST_LOCK  = 3'h5;
	localparam RET_CYC  = CYCLE_CYCLES - STEP_CYCLES * (`GVPS_EVAC_STEPS + `GVPS_PRES_STEPS);

	wire [3:0] sin;
	wire       sw_high = sin[0];
	wire       dem     = sin[1];
	wire       rst_btn = sin[2] | sin[3];

	reg  [2:0]  state;
	reg  [31:0] pre;
	reg  [31:0] vcnt;
	reg  [31:0] rcnt;
	reg  [4:0]  step;
	reg         dem_d;
	reg         btn_d;
	reg         after_lock;

	gvps_sync #(.WIDTH(4)) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.din  ({reset_remote, reset_front, burner_demand, press_high}),
		.dout (sin)
	);

	wire step_tick  = (pre == STEP_CYCLES - 1);
	wire dem_rise   = dem & ~dem_d;
	wire dem_fall   = ~dem & dem_d;
	wire btn_press  = rst_btn & ~btn_d;

	function start_ok;
		input [1:0] mode;
		input       rise;
		input       fall;
		begin
			case (mode)
				`GVPS_MODE_PRESTART: start_ok = rise;
				`GVPS_MODE_POSTSTOP: start_ok = fall;
				`GVPS_MODE_BOTH:     start_ok = rise | fall;
				default:             start_ok = rise;
			endcase
		end
	endfunction

	always @(posedge clk) begin
		if (!nrst) begin
			state      <= ST_IDLE;
			pre        <= 32'h0;
			vcnt       <= 32'h0;
			rcnt       <= 32'h0;
			step       <= 5'h0;
			dem_d      <= 1'b0;
			btn_d      <= 1'b0;
			after_lock <= 1'b0;
			valve_down <= 1'b0;
			valve_up   <= 1'b0;
			relay_main <= 1'b0;
			relay_aux  <= 1'b0;
			lockout    <= 1'b0;
			reset_lamp <= 1'b0;
			ind_phase  <= `GVPS_PH_IDLE;
			ind_step   <= 5'h0;
		end else begin
			dem_d <= dem;
			btn_d <= rst_btn;
			if (state == ST_EVAC || state == ST_PRES) begin
				pre <= step_tick ? 32'h0 : pre + 32'h1;
			end else begin
				pre <= 32'h0;
			end
			case (state)
				ST_IDLE, ST_RUN: begin
					if (state == ST_RUN && !dem) begin
						relay_main <= 1'b0;
						relay_aux  <= 1'b0;
					end
					if (after_lock || start_ok(start_mode, dem_rise, dem_fall)) begin
						after_lock <= 1'b0;
						relay_main <= 1'b0;
						relay_aux  <= 1'b0;
						state      <= ST_EVAC;
						step       <= 5'h0;
						vcnt       <= 32'h0;
						valve_down <= 1'b1;
						ind_phase  <= `GVPS_PH_EVAC;
						ind_step   <= 5'h0;
					end else if (state == ST_IDLE && dem && start_mode == `GVPS_MODE_POSTSTOP) begin
						relay_main <= 1'b1;
						relay_aux  <= 1'b1;
						state      <= ST_RUN;
					end
				end
				ST_EVAC: begin
					vcnt <= vcnt + 32'h1;
					if (vcnt == VALVE_CYCLES - 1) begin
						valve_down <= 1'b0;
					end
					if (step_tick) begin
						step     <= step + 5'h1;
						ind_step <= step + 5'h1;
					end
					if (vcnt >= VALVE_CYCLES && sw_high) begin
						state      <= ST_LOCK;
						valve_down <= 1'b0;
					end else if (step_tick && step == `GVPS_EVAC_STEPS - 5'h1) begin
						state      <= ST_PRES;
						step       <= 5'h0;
						vcnt       <= 32'h0;
						valve_down <= 1'b0;
						valve_up   <= 1'b1;
						ind_phase  <= `GVPS_PH_PRES;
						ind_step   <= 5'h0;
					end
				end
				ST_PRES: begin
					vcnt <= vcnt + 32'h1;
					if (vcnt == VALVE_CYCLES - 1) begin
						valve_up <= 1'b0;
					end
					if (step_tick) begin
						step     <= step + 5'h1;
						ind_step <= step + 5'h1;
					end
					if (vcnt >= VALVE_CYCLES && !sw_high) begin
						state    <= ST_LOCK;
						valve_up <= 1'b0;
					end else if (step_tick && step == `GVPS_PRES_STEPS - 5'h1) begin
						state      <= ST_RET;
						rcnt       <= 32'h0;
						valve_up   <= 1'b0;
						relay_main <= 1'b1;
						relay_aux  <= 1'b1;
						ind_phase  <= `GVPS_PH_RETURN;
					end
				end
				ST_RET: begin
					rcnt <= rcnt + 32'h1;
					if (rcnt == RET_CYC - 1) begin
						state     <= dem ? ST_RUN : ST_IDLE;
						ind_phase <= `GVPS_PH_IDLE;
						ind_step  <= 5'h0;
						if (!dem) begin
							relay_main <= 1'b0;
							relay_aux  <= 1'b0;
						end
					end
				end
				ST_LOCK: begin
					// Outputs off, indication, lamp, frozen dial
					lockout    <= 1'b1;
					reset_lamp <= 1'b1;
					valve_down <= 1'b0;
					valve_up   <= 1'b0;
					relay_main <= 1'b0;
					relay_aux  <= 1'b0;
					if (btn_press) begin
						lockout    <= 1'b0;
						reset_lamp <= 1'b0;
						after_lock <= 1'b1;
						state      <= ST_IDLE;
						ind_phase  <= `GVPS_PH_IDLE;
						ind_step   <= 5'h0;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // gvps_top
`default_nettype wire

// ===== test/gvps_asserts.sv
// Assertion checker for the proving sequencer
`timescale 1ns/100ps
`default_nettype none
module gvps_asserts #(
	parameter VALVE_CYCLES = 30
) (
	// Clock, reset and buttons
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       reset_front,
	input wire logic       reset_remote,
	// Outputs watched
	input wire logic       valve_down,
	input wire logic       valve_up,
	input wire logic       relay_main,
	input wire logic       relay_aux,
	input wire logic       lockout,
	input wire logic       reset_lamp,
	input wire logic [2:0] ind_phase,
	input wire logic [4:0] ind_step
);
	logic [31:0] dn_cnt;
	logic [31:0] up_cnt;
	logic [3:0]  rs_age;
	always_ff @(posedge clk) begin
		dn_cnt <= valve_down ? dn_cnt + 32'h1 : 32'h0;
		up_cnt <= valve_up ? up_cnt + 32'h1 : 32'h0;
		if (!nrst || rs_age == 4'hf)
			rs_age <= 4'hf;
		else
			rs_age <= rs_age + 4'h1;
		if (reset_front || reset_remote)
			rs_age <= 4'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_LOCK_QUIET: assert property (lockout |-> !(valve_down | valve_up | relay_main | relay_aux))
		else $error("output live in lockout");
	AST_LAMP: assert property (reset_lamp == lockout)
		else $error("lamp differs from lockout");
	AST_DIAL_FROZEN: assert property (lockout && $past(lockout) |-> $stable(ind_phase) && $stable(ind_step))
		else $error("dial moved in lockout");
	AST_RELAY_PAIR: assert property (relay_main == relay_aux)
		else $error("relays differ");
	AST_DOWN_LEN: assert property ($fell(valve_down) |-> dn_cnt == VALVE_CYCLES)
		else $error("downstream valve time wrong");
	AST_UP_LEN: assert property ($fell(valve_up) |-> up_cnt == VALVE_CYCLES)
		else $error("upstream valve time wrong");
	AST_DOWN_START: assert property ($rose(valve_down) |-> ind_phase == 3'h1 && ind_step == 5'h00)
		else $error("evacuation start wrong");
	AST_UP_START: assert property ($rose(valve_up) |-> ind_phase == 3'h2 && $past(ind_phase) == 3'h1)
		else $error("pressurization start wrong");
	AST_RESET_CAUSE: assert property ($fell(lockout) |-> rs_age < 4'h8)
		else $error("lockout left without press");
	AST_NO_OVERLAP: assert property (!(valve_down && valve_up))
		else $error("both valves open");
endmodule // gvps_asserts
bind gvps_top gvps_asserts #(.VALVE_CYCLES(VALVE_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
	.reset_front(reset_front), .reset_remote(reset_remote), .valve_down(valve_down), .valve_up(valve_up),
	.relay_main(relay_main), .relay_aux(relay_aux), .lockout(lockout), .reset_lamp(reset_lamp),
	.ind_phase(ind_phase), .ind_step(ind_step));
`default_nettype wire

// ===== test/gvps_gas_model.sv
// Inter-valve pressure model with injectable leaks
`timescale 1ns/100ps
`default_nettype none
module gvps_gas_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Valves and leak faults
	input  wire logic valve_down,
	input  wire logic valve_up,
	input  wire logic leak_up,
	input  wire logic leak_down,
	// Switch level
	output var  logic press_high
);
	always_ff @(posedge clk) begin
		if (!nrst || valve_down)
			press_high <= 1'b0;
		else if (valve_up || leak_up)
			press_high <= 1'b1;
		else if (leak_down)
			press_high <= 1'b0;
	end
endmodule // gvps_gas_model
`default_nettype wire

// ===== test/gvps_top_test.sv
// Self-checking bench for the proving sequencer
`timescale 1ns/100ps
`default_nettype none
module gvps_top_test;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic [1:0] start_mode = 2'h0;
	logic       burner_demand = 1'b0;
	logic       reset_front = 1'b0;
	logic       reset_remote = 1'b0;
	logic       leak_up = 1'b0;
	logic       leak_down = 1'b0;
	wire        press_high, valve_down, valve_up, relay_main, relay_aux, lockout, reset_lamp;
	wire  [2:0] ind_phase;
	wire  [4:0] ind_step;
	integer     n_fail = 0;
	integer     checked = 0;
	integer     i, r;
	logic [6:0] rows [0:3] = '{7'h00, 7'h11, 7'h4a, 7'h60};
	always #10 clk = ~clk;
	gvps_top #(.STEP_CYCLES(20), .VALVE_CYCLES(30), .CYCLE_CYCLES(600)) dut (.clk(clk), .nrst(nrst),
		.start_mode(start_mode), .burner_demand(burner_demand), .press_high(press_high),
		.reset_front(reset_front), .reset_remote(reset_remote), .valve_down(valve_down), .valve_up(valve_up),
		.relay_main(relay_main), .relay_aux(relay_aux), .lockout(lockout), .reset_lamp(reset_lamp),
		.ind_phase(ind_phase), .ind_step(ind_step));
	gvps_gas_model gas (.clk(clk), .nrst(nrst), .valve_down(valve_down), .valve_up(valve_up),
		.leak_up(leak_up), .leak_down(leak_down), .press_high(press_high));
	task chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task restart;
		nrst = 1'b0;
		burner_demand = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (6) @(negedge clk);
	endtask
	task wait_end;
		i = 0;
		while (lockout !== 1'b1 && !(relay_main === 1'b1 && ind_phase === 3'h0) && i < 1000) begin
			@(negedge clk);
			i++;
		end
	endtask
	task press(input logic front);
		reset_front = front;
		reset_remote = !front;
		repeat (6) @(negedge clk);
		reset_front = 1'b0;
		reset_remote = 1'b0;
		for (i = 0; i < 20 && valve_down !== 1'b1; i++)
			@(negedge clk);
	endtask
	initial begin
		repeat (4) @(negedge clk);
		chk(valve_down === 1'b0 && lockout === 1'b0 && relay_main === 1'b0 && ind_phase === 3'h0, "reset");
		for (r = 0; r < 4; r++) begin
			restart;
			{start_mode, leak_up, leak_down} = rows[r][6:3];
			burner_demand = 1'b1;
			wait_end;
			if (rows[r][2:0] == 3'h0)
				chk(i >= 600 && i <= 612 && relay_aux === 1'b1, "cycle");
			else
				chk(lockout === 1'b1 && ind_phase === rows[r][2:0] && reset_lamp === 1'b1, "lock");
		end
		repeat (30) @(negedge clk);
		chk(relay_main === 1'b1 && ind_phase === 3'h0 && valve_down === 1'b0, "hold");
		restart;
		leak_up = 1'b1;
		burner_demand = 1'b1;
		wait_end;
		leak_up = 1'b0;
		press(1'b0);
		chk(valve_down === 1'b1 && lockout === 1'b0, "remote");
		wait_end;
		chk(relay_main === 1'b1, "rerun");
		restart;
		leak_down = 1'b1;
		burner_demand = 1'b1;
		wait_end;
		repeat (100) @(negedge clk);
		chk(lockout === 1'b1 && ind_phase === 3'h2 && valve_up === 1'b0, "frozen");
		chk(ind_step === 5'h01, "step");
		leak_down = 1'b0;
		press(1'b1);
		chk(valve_down === 1'b1 && lockout === 1'b0, "front");
		restart;
		start_mode = 2'h1;
		burner_demand = 1'b1;
		repeat (10) @(negedge clk);
		chk(relay_main === 1'b1 && valve_down === 1'b0, "post");
		burner_demand = 1'b0;
		repeat (10) @(negedge clk);
		chk(valve_down === 1'b1, "poststart");
		report_and_stop;
	end
	initial begin
		#(20 * 12000);
		n_fail++;
		report_and_stop;
	end
endmodule // gvps_top_test
`default_nettype wire
